// ===== verilog/stack_bus_serial_port_glue.sv
`timescale 1ns/1ps
// Behaviour
// - window is eight consecutive io addresses
// - a9..a3 compared with seven base switches
// - closed switch needs zero, open needs one
// - base 300 hex matches 1100000 pattern
// - eighth switch closed enables the port
// - interrupt is tri-state, shareable, optional pulldown
// - interrupt routed to one of nine lines
// - default base 3f8 and request line 4
// - jumper set: rts gates driver; else always
// - uart registers with fifos sit behind window
// - dte: drive td rts dtr, sample rest
// - only ten low address bits decoded
module stack_bus_serial_port_glue (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [6:0] base_select_switch_n,
  input wire logic port_enable_switch_n,
  input wire logic [8:0] irq_route_header,
  input wire logic line_driver_enable_jumper,
  input wire logic uart_irq,
  input wire logic uart_rts,
  input wire logic uart_dtr,
  input wire logic uart_td,
  input wire logic rx_data_pin,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic cd_pin,
  input wire logic ri_pin,
  output logic uart_cs,
  output logic [2:0] uart_reg_sel,
  output logic uart_rd,
  output logic uart_wr,
  output logic [8:0] irq_out,
  output logic [8:0] irq_oe,
  output logic line_driver_en,
  output logic td_pin,
  output logic rts_pin,
  output logic dtr_pin,
  output logic uart_rx,
  output logic uart_cts,
  output logic uart_dsr,
  output logic uart_cd,
  output logic uart_ri
);
  logic [6:0] sw_s;
  logic en_n_s;
  logic [8:0] route_s;
  logic jmp_s;
  logic [4:0] modem_s;
  logic [1:0] strb_s;

  // switches, jumpers and cable inputs are all asynchronous to core_clk
  sync2 #(.W(23)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d({base_select_switch_n, port_enable_switch_n, irq_route_header,
        line_driver_enable_jumper, rx_data_pin, cts_pin, dsr_pin,
        cd_pin, ri_pin}),
    .q({sw_s, en_n_s, route_s, jmp_s, modem_s})
  );

  // bus strobes come from the stack bus, also a foreign timing domain
  sync2 #(.W(2)) u_strb (
    .core_clk(core_clk),
    .rst(rst),
    .d({~io_rd_n, ~io_wr_n}),
    .q(strb_s)
  );

  logic [15:0] addr_r;
  logic [15:0] addr_nxt;
  serial_glue_pkg::dec_state_t st_r;
  serial_glue_pkg::dec_state_t st_nxt;
  logic cs_r, cs_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic rd_r, rd_nxt;
  logic wr_r, wr_nxt;
  logic hit;
  logic port_on;
  logic [6:0] want;

  // open switch reads 1 on the pin, which is the required address bit
  always_comb begin
    want = sw_s;
    port_on = ~en_n_s;
    // only a9..a3 take part; a15..a10 never looked at
    hit = (addr_r[serial_glue_pkg::ADDR_BITS-1:serial_glue_pkg::SEL_LSB]
           == want);
  end

  // decode: one address flop is enough; address is steady across a strobe
  always_comb begin
    addr_nxt = io_addr;
    st_nxt = st_r;
    cs_nxt = 1'b0;
    sel_nxt = sel_r;
    rd_nxt = 1'b0;
    wr_nxt = 1'b0;
    case (st_r)
      serial_glue_pkg::ST_IDLE: begin
        if (!port_on) begin
          st_nxt = serial_glue_pkg::ST_OFF;
        end else if (hit && (strb_s != 2'h0)) begin
          st_nxt = serial_glue_pkg::ST_CLAIM;
          cs_nxt = 1'b1;
          sel_nxt = addr_r[serial_glue_pkg::SEL_LSB-1:0];
          rd_nxt = strb_s[1];
          wr_nxt = strb_s[0];
        end
      end
      serial_glue_pkg::ST_CLAIM: begin
        // hold claim until the strobe drops; one uart access per strobe
        if (!port_on) begin
          st_nxt = serial_glue_pkg::ST_OFF;
        end else if (strb_s == 2'h0) begin
          st_nxt = serial_glue_pkg::ST_IDLE;
        end else begin
          cs_nxt = 1'b1;
          rd_nxt = strb_s[1];
          wr_nxt = strb_s[0];
        end
      end
      serial_glue_pkg::ST_OFF: begin
        if (port_on) begin
          st_nxt = serial_glue_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = serial_glue_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_r <= 16'h0000;
      st_r <= serial_glue_pkg::ST_IDLE;
      cs_r <= 1'b0;
      sel_r <= 3'h0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      st_r <= st_nxt;
      cs_r <= cs_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
    end
  end

  logic [8:0] irq_oe_r, irq_oe_nxt;
  logic [8:0] irq_out_r, irq_out_nxt;
  logic drv_r, drv_nxt;
  logic [2:0] tx_r, tx_nxt;
  logic [4:0] mdm_r, mdm_nxt;
  logic [8:0] route_one;

  // irq: only the first selected header position is used, so never two
  always_comb begin
    route_one = route_s & (~route_s + 9'h001);
    irq_out_nxt = route_one & {9{uart_irq}};
    // driven only while asserted; otherwise float so boards can share
    irq_oe_nxt = port_on ? (route_one & {9{uart_irq}}) : 9'h000;
    drv_nxt = jmp_s ? uart_rts : 1'b1;
    tx_nxt = {uart_td, uart_rts, uart_dtr};
    mdm_nxt = modem_s;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_oe_r <= 9'h000;
      irq_out_r <= 9'h000;
      drv_r <= 1'b0;
      tx_r <= 3'h4;
      mdm_r <= 5'h00;
    end else begin
      irq_oe_r <= irq_oe_nxt;
      irq_out_r <= irq_out_nxt;
      drv_r <= drv_nxt;
      tx_r <= tx_nxt;
      mdm_r <= mdm_nxt;
    end
  end

  assign uart_cs = cs_r;
  assign uart_reg_sel = sel_r;
  assign uart_rd = rd_r;
  assign uart_wr = wr_r;
  assign irq_out = irq_out_r;
  assign irq_oe = irq_oe_r;
  assign line_driver_en = drv_r;
  assign td_pin = tx_r[2];
  assign rts_pin = tx_r[1];
  assign dtr_pin = tx_r[0];
  assign {uart_rx, uart_cts, uart_dsr, uart_cd, uart_ri} = mdm_r;
endmodule

// ===== include/serial_glue_pkg.sv
package serial_glue_pkg;
  // address window
  localparam int ADDR_BITS = 10;
  localparam int SEL_LSB = 3;
  localparam int SEL_W = 7;
  localparam int WIN_SIZE = 8;
  // all base switches open: pin levels 1111111 decode base 3f8
  localparam logic [6:0] SW_DEFAULT = 7'h7F;
  // irq routing: one-hot over the nine request lines
  localparam int IRQ_LINES = 9;
  localparam int IRQ_2_9 = 0;
  localparam int IRQ_3 = 1;
  localparam int IRQ_4 = 2;
  localparam int IRQ_5 = 3;
  localparam int IRQ_7 = 4;
  localparam int IRQ_10 = 5;
  localparam int IRQ_11 = 6;
  localparam int IRQ_12 = 7;
  localparam int IRQ_15 = 8;
  localparam logic [8:0] IRQ_ROUTE_DEFAULT = 9'h004;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CLAIM = 3'h2,
    ST_OFF = 3'h4
  } dec_state_t;
endpackage

// ===== verilog/sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for a bundle of slow pins
module sync2 #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  // first stage feeds only the second stage
  always_comb begin
    s1_nxt = d;
    s2_nxt = s1_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;
endmodule

// ===== test/host_bus_model.sv
`timescale 1ns/1ps
// host cpu: no ready line, so each strobe runs a fixed length
module host_bus_model (
  input wire logic core_clk,
  output logic [15:0] io_addr = 16'h0000,
  output logic io_rd_n = 1'h1,
  output logic io_wr_n = 1'h1
);
  // address stays put after release so the decode never sees a glitch
  task access(input logic [15:0] a, input logic wr);
    io_addr = a;
    io_rd_n = wr;
    io_wr_n = !wr;
    repeat (6) @(negedge core_clk);
    {io_rd_n, io_wr_n} = 2'h3;
    repeat (4) @(negedge core_clk);
  endtask
endmodule

// ===== test/stack_bus_serial_port_glue_assertions.sv
`timescale 1ns/1ps
// pin-level checks on the glue
module glue_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_rd_n,
  input wire logic [6:0] base_select_switch_n,
  input wire logic port_enable_switch_n,
  input wire logic uart_cs,
  input wire logic [2:0] uart_reg_sel,
  input wire logic [8:0] irq_out,
  input wire logic [8:0] irq_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // strobes pass two sync flops and a register
  property p_rise;
    $fell(io_rd_n) && io_addr[9:3] == base_select_switch_n
      && !port_enable_switch_n |-> ##[2:3] uart_cs;
  endproperty
  property p_drop; $rose(io_rd_n) |-> ##[2:3] !uart_cs; endproperty
  property p_stay; uart_cs && !io_rd_n |=> uart_cs; endproperty
  property p_hit;
    uart_cs |-> io_addr[9:3] == base_select_switch_n;
  endproperty
  property p_sel; uart_cs |-> uart_reg_sel == io_addr[2:0]; endproperty
  property p_off;
    port_enable_switch_n[*4] |-> irq_oe == 9'h000 && !uart_cs;
  endproperty
  property p_drive; (irq_oe & ~irq_out) == 9'h000; endproperty
  property p_one; $onehot0(irq_oe); endproperty
  a_rise: assert property (p_rise) else $error("no claim");
  a_drop: assert property (p_drop) else $error("no drop");
  a_stay: assert property (p_stay) else $error("early drop");
  a_hit: assert property (p_hit) else $error("bad claim");
  a_sel: assert property (p_sel) else $error("bad sel");
  a_off: assert property (p_off) else $error("port on");
  a_drive: assert property (p_drive) else $error("irq low");
  a_one: assert property (p_one) else $error("irq lines");
  c_claim: cover property ($rose(uart_cs));
  c_irq: cover property (irq_oe != 9'h000);
  c_off: cover property (port_enable_switch_n && !io_rd_n);
endmodule
bind stack_bus_serial_port_glue glue_chk u_glue_chk (.*);

// ===== test/test_stack_bus_serial_port_glue.sv
`timescale 1ns/1ps
module test_stack_bus_serial_port_glue;
  logic core_clk = 1'h0, rst = 1'h1, port_enable_switch_n = 1'h0;
  logic line_driver_enable_jumper = 1'h0, uart_irq = 1'h0, uart_rts = 1'h0;
  logic uart_dtr = 1'h0, uart_td = 1'h1, rx_data_pin = 1'h1, cts_pin = 1'h0;
  logic dsr_pin = 1'h0, cd_pin = 1'h0, ri_pin = 1'h0, io_rd_n, io_wr_n;
  logic uart_cs, uart_rd, uart_wr, line_driver_en, td_pin, rts_pin, dtr_pin;
  logic uart_rx, uart_cts, uart_dsr, uart_cd, uart_ri;
  logic [6:0] base_select_switch_n = serial_glue_pkg::SW_DEFAULT;
  logic [8:0] irq_route_header = serial_glue_pkg::IRQ_ROUTE_DEFAULT;
  logic [8:0] irq_out, irq_oe;
  logic [15:0] io_addr;
  logic [2:0] uart_reg_sel;
  int mismatches = 0, checked = 0;
  stack_bus_serial_port_glue u_stack_bus_serial_port_glue (.*);
  host_bus_model u_host_bus_model (.*);
  // 200 MHz bus clock
  always #2.5 core_clk = ~core_clk;
  task chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle, judged while the strobe is still low
  task acc(input logic [15:0] a, input logic wr, input logic hit);
    fork
      u_host_bus_model.access(a, wr);
      begin
        repeat (5) @(negedge core_clk);
        chk({uart_cs, uart_rd, uart_wr, hit ? uart_reg_sel : 3'h0},
            {hit, hit & !wr, hit & wr, a[2:0] & {3{hit}}});
      end
    join
  endtask
  // open switches give 3f8; bits above a9 are ignored
  task t_decode;
    acc(16'h03FF, 1'h1, 1'h1);
    acc(16'hFC00, 1'h0, 1'h0);
    acc(16'hFFFA, 1'h0, 1'h1);
    base_select_switch_n = 7'h60;
    repeat (4) @(negedge core_clk);
    acc(16'h0305, 1'h1, 1'h1);
    acc(16'h0385, 1'h0, 1'h0);
  endtask
  // a disabled port ignores its window and floats the irq
  task t_off;
    port_enable_switch_n = 1'h1;
    uart_irq = 1'h1;
    acc(16'h0300, 1'h0, 1'h0);
    acc(16'h0307, 1'h1, 1'h0);
    chk(irq_oe, 9'h000);
    port_enable_switch_n = 1'h0;
  endtask
  // every header position carries the request alone
  task t_irq;
    repeat (4) @(negedge core_clk);
    chk({irq_oe, irq_out}, {2{9'h001 << serial_glue_pkg::IRQ_4}});
    for (int i = 0; i < 9; i++) begin
      irq_route_header = 9'h001 << i;
      repeat (4) @(negedge core_clk);
      chk({irq_oe, irq_out}, {2{9'h001 << i}});
    end
    // two header positions fitted: only the lower one is driven
    irq_route_header = 9'h0C0;
    repeat (4) @(negedge core_clk);
    chk(irq_oe, 9'h040);
    uart_irq = 1'h0;
    repeat (4) @(negedge core_clk);
    chk({irq_oe, irq_out}, 18'h00000);
  endtask
  // jumper out keeps the driver on; in, rts gates it
  task t_drv;
    logic [3:0] m;
    for (int j = 0; j < 4; j++) begin
      m = {j[1], !j[1], j[0], !j[0]};
      {line_driver_enable_jumper, uart_rts} = 2'(j);
      {uart_td, uart_dtr, rx_data_pin} = {3{j[0]}};
      {cts_pin, dsr_pin, cd_pin, ri_pin} = m;
      repeat (4) @(negedge core_clk);
      // jumper in, rts low: our driver must let go of the shared pair
      chk(line_driver_en, !j[1] | j[0]);
      chk({td_pin, rts_pin, dtr_pin, uart_rx}, {4{j[0]}});
      chk({uart_cts, uart_dsr, uart_cd, uart_ri}, m);
    end
  endtask
  task finish_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(negedge core_clk);
    rst = 1'h0;
    repeat (4) @(negedge core_clk);
    t_decode();
    t_off();
    t_irq();
    t_drv();
    finish_test();
  end
  // a hang counts as a failure
  initial begin
    #20000;
    mismatches++;
    finish_test();
  end
endmodule
